/* File: rtl/dsp_ctrl_pkg.sv */
// Shared constants for the signal processor run and memory protection block
package dsp_ctrl_pkg;

	// ------------------------------------------------------------------
	// Data memory window
	// ------------------------------------------------------------------
	localparam logic [15:0] DMEM_FIRST = 16'h4380;
	localparam logic [15:0] DMEM_LAST  = 16'h43be;
	localparam int          DMEM_DEPTH = 63;
	localparam int          DMEM_AW    = 6;
	localparam int          DMEM_WIDTH = 28;

	// ------------------------------------------------------------------
	// Write protection key and control
	// ------------------------------------------------------------------
	localparam logic [15:0] PROT_KEY_ADDR  = 16'he7fe;
	localparam logic [15:0] PROT_CTRL_ADDR = 16'he7e3;
	localparam logic [7:0]  PROT_KEY       = 8'had;
	localparam logic [7:0]  PROT_ON        = 8'h80;
	localparam logic [7:0]  PROT_OFF       = 8'h00;

	// ------------------------------------------------------------------
	// Control and status registers
	// ------------------------------------------------------------------
	localparam logic [15:0] RUN_ADDR           = 16'he800;
	localparam logic [15:0] STATUS_ZERO_ADDR   = 16'he804;
	localparam logic [15:0] IRQ_MASK_ZERO_ADDR = 16'he808;
	localparam logic [15:0] CFG_TWO_ADDR       = 16'he80c;
	localparam logic [15:0] PHCAL_A_ADDR = 16'he810;
	localparam logic [15:0] PHCAL_B_ADDR = 16'he811;
	localparam logic [15:0] PHCAL_C_ADDR = 16'he812;

	localparam logic [15:0] RUN_START = 16'h0001;
	localparam logic [15:0] RUN_STOP  = 16'h0000;
	localparam logic [15:0] RUN_RESET = 16'h0000;
	localparam int          DONE_BIT   = 17;
	localparam int          EXTREF_BIT = 0;

	// ------------------------------------------------------------------
	// Phase calibration encoding
	// ------------------------------------------------------------------
	localparam int                PHCAL_W       = 10;
	localparam int                PHCAL_BUS_W   = 16;
	localparam logic [PHCAL_W-1:0] PHCAL_POS_OFS = 10'h200;
	localparam logic [PHCAL_W-1:0] PHCAL_MAX_ADV = 10'h17f;
	localparam logic [PHCAL_W-1:0] PHCAL_MAX_DLY = 10'h03f;
	localparam int                PHASE_LSB_PS  = 976;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int SYS_CLK_HZ   = 50_000_000;
	localparam int PASS_RATE_HZ = 8000;
	localparam int PASS_CYCLES  = SYS_CLK_HZ / PASS_RATE_HZ;

	typedef enum logic [1:0] {
		PM_FULL    = 2'b00,
		PM_REDUCED = 2'b01,
		PM_LOW     = 2'b10,
		PM_SLEEP   = 2'b11
	} power_mode_e;

	typedef enum logic [2:0] {
		SEL_NONE   = 3'b000,
		SEL_DMEM   = 3'b001,
		SEL_RUN    = 3'b010,
		SEL_STATUS = 3'b011,
		SEL_MASK   = 3'b100,
		SEL_CFG2   = 3'b101,
		SEL_PHCAL  = 3'b110
	} rd_sel_e;

endpackage

/* File: rtl/dsp_data_ram.sv */
// Data memory with registered read and reset-to-zero valid tags
`timescale 1ns/1ns
`default_nettype none
module dsp_data_ram #(
	parameter int DEPTH = 63,
	parameter int AW    = 6,
	parameter int WIDTH = 28
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	// Write port
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    wrAddr,
	input  wire logic [WIDTH-1:0] wrData,
	// Read port
	input  wire logic [AW-1:0]    rdAddr,
	output logic      [WIDTH-1:0] rdData_ff
);
	if (DEPTH > (1 << AW)) begin : g_bad_depth
		$error("dsp_data_ram: DEPTH does not fit AW");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [DEPTH-1:0] written_ff;
	logic [DEPTH-1:0] nxt_written;
	logic [WIDTH-1:0] nxt_rdData;

	// Valid tags make every word read zero after reset without a clear sweep
	always_comb begin
		nxt_written = written_ff;
		if (wrEn && (int'(wrAddr) < DEPTH))
			nxt_written[wrAddr] = 1'b1;
		nxt_rdData = '0;
		if ((int'(rdAddr) < DEPTH) && written_ff[rdAddr])
			nxt_rdData = mem[rdAddr];
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			written_ff <= '0;
			rdData_ff  <= '0;
		end else begin
			written_ff <= nxt_written;
			rdData_ff  <= nxt_rdData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (wrEn && (int'(wrAddr) < DEPTH))
			mem[wrAddr] <= wrData;
	end
endmodule // dsp_data_ram
`default_nettype wire

/* File: rtl/dsp_run_ram_protect.sv */
// Run control, pass timer, done flag, protected data memory and calibration
`timescale 1ns/1ns
`default_nettype none
module dsp_run_ram_protect
	import dsp_ctrl_pkg::*;
#(
	parameter int PASS_CYCLES_P = PASS_CYCLES
) (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    resetn,
	// Register port, from the serial port decoder
	input  wire logic                    regWrite,
	input  wire logic                    regRead,
	input  wire logic [15:0]             regAddr,
	input  wire logic [31:0]             regWdata,
	output logic      [31:0]             regRdata,
	output logic                         regRvalid,
	// Power mode from the power manager
	input  wire logic [1:0]              powerMode,
	// Processor facing outputs
	output logic                         dspRunning,
	output logic                         passStrobe,
	output logic                         externalRefSelect,
	output logic      [2:0][PHCAL_W-1:0] phaseShift,
	output logic                         interruptZeroN
);
	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (PASS_CYCLES_P < 2) begin : g_bad_pass
		$error("dsp_run_ram_protect: PASS_CYCLES_P must be at least 2");
	end

	localparam int CNT_W = $clog2(PASS_CYCLES_P);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PASS_CYCLES_P - 1);

	function automatic logic phcalLegal(input logic [31:0] v);
		logic [PHCAL_W-1:0] c;
		c = v[PHCAL_W-1:0];
		phcalLegal = (v[31:PHCAL_W] == '0) &&
			((c <= PHCAL_MAX_ADV) ||
			 ((c > PHCAL_POS_OFS) && (c <= PHCAL_POS_OFS + PHCAL_MAX_DLY)));
	endfunction

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	logic               inDmem;
	logic [15:0]        dmemOfs;
	logic [DMEM_AW-1:0] dmemIdx;
	logic               wrDmemOk;
	logic               wrKey;
	logic               wrProt;
	logic [1:0]         phIdx;
	logic               isPhcal;
	logic               protect_ff;

	always_comb begin
		inDmem   = (regAddr >= DMEM_FIRST) && (regAddr <= DMEM_LAST);
		dmemOfs  = regAddr - DMEM_FIRST;
		dmemIdx  = dmemOfs[DMEM_AW-1:0];
		wrDmemOk = regWrite && inDmem && !protect_ff;
		wrKey    = regWrite && (regAddr == PROT_KEY_ADDR);
		wrProt   = regWrite && (regAddr == PROT_CTRL_ADDR);
		isPhcal  = (regAddr >= PHCAL_A_ADDR) && (regAddr <= PHCAL_C_ADDR);
		phIdx    = 2'(regAddr - PHCAL_A_ADDR);
	end

	// ------------------------------------------------------------------
	// Control state
	// ------------------------------------------------------------------
	logic [15:0]              run_ff, nxt_run;
	logic                     nxt_protect;
	logic                     keyArmed_ff, nxt_keyArmed;
	logic                     done_ff, nxt_done;
	logic                     mask_ff, nxt_mask;
	logic                     extRef_ff, nxt_extRef;
	logic [CNT_W-1:0]         cnt_ff, nxt_cnt;
	logic                     tick;
	logic [PHCAL_W-1:0]       phCal_ff [3];
	logic [PHCAL_W-1:0]       nxt_phCal [3];
	logic [2:0][PHCAL_W-1:0]  nxt_shift;

	always_comb begin
		nxt_run      = run_ff;
		nxt_protect  = protect_ff;
		nxt_mask     = mask_ff;
		nxt_extRef   = extRef_ff;
		nxt_phCal    = phCal_ff;
		tick         = (cnt_ff == CNT_LAST);
		nxt_cnt      = tick ? '0 : cnt_ff + 1'b1;
		// Any register write other than the key disarms it
		nxt_keyArmed = regWrite ? (wrKey && regWdata[7:0] == PROT_KEY)
			: keyArmed_ff;
		if (wrProt && keyArmed_ff) begin
			if (regWdata[7:0] == PROT_ON)
				nxt_protect = 1'b1;
			else if (regWdata[7:0] == PROT_OFF)
				nxt_protect = 1'b0;
		end
		if (regWrite && regAddr == RUN_ADDR)
			nxt_run = regWdata[15:0];
		if (regWrite && regAddr == IRQ_MASK_ZERO_ADDR)
			nxt_mask = regWdata[DONE_BIT];
		// Reference select only moves in full power so it holds elsewhere
		if (regWrite && regAddr == CFG_TWO_ADDR && powerMode == PM_FULL)
			nxt_extRef = regWdata[EXTREF_BIT];
		if (regWrite && isPhcal && phcalLegal(regWdata))
			nxt_phCal[phIdx] = regWdata[PHCAL_W-1:0];
		// Set beats a clear arriving in the same cycle
		nxt_done = done_ff;
		if (regWrite && regAddr == STATUS_ZERO_ADDR && regWdata[DONE_BIT])
			nxt_done = 1'b0;
		if (tick && run_ff == RUN_START)
			nxt_done = 1'b1;
		// Signed LSB shift, negative advances and positive delays the path
		for (int i = 0; i < 3; i++) begin
			if (phCal_ff[i] > PHCAL_POS_OFS)
				nxt_shift[i] = phCal_ff[i] - PHCAL_POS_OFS;
			else
				nxt_shift[i] = PHCAL_W'(0) - phCal_ff[i];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			run_ff            <= RUN_RESET;
			protect_ff        <= 1'b0;
			keyArmed_ff       <= 1'b0;
			done_ff           <= 1'b0;
			mask_ff           <= 1'b0;
			extRef_ff         <= 1'b0;
			cnt_ff            <= '0;
			phCal_ff          <= '{default: '0};
			phaseShift        <= '0;
			dspRunning        <= 1'b0;
			passStrobe        <= 1'b0;
			externalRefSelect <= 1'b0;
			interruptZeroN    <= 1'b1;
		end else begin
			run_ff            <= nxt_run;
			protect_ff        <= nxt_protect;
			keyArmed_ff       <= nxt_keyArmed;
			done_ff           <= nxt_done;
			mask_ff           <= nxt_mask;
			extRef_ff         <= nxt_extRef;
			cnt_ff            <= nxt_cnt;
			phCal_ff          <= nxt_phCal;
			phaseShift        <= nxt_shift;
			dspRunning        <= (run_ff == RUN_START);
			passStrobe        <= tick && (run_ff == RUN_START);
			externalRefSelect <= extRef_ff;
			interruptZeroN    <= !(done_ff && mask_ff);
		end
	end

	// ------------------------------------------------------------------
	// Two stage write pipeline into data memory
	// ------------------------------------------------------------------
	logic                  st1Valid_ff, st2Valid_ff;
	logic [DMEM_AW-1:0]    st1Addr_ff, st2Addr_ff;
	logic [DMEM_WIDTH-1:0] st1Data_ff, st2Data_ff;
	logic                  ramWe;
	logic [DMEM_WIDTH-1:0] ramRd;
	logic [1:0]            wrSeen_ff, nxt_wrSeen;

	// A word lands in memory only when two later writes push it out
	assign ramWe = wrDmemOk && st2Valid_ff;
	// Saturating count of accepted memory writes, only for a_commit_late
	assign nxt_wrSeen = (wrSeen_ff == 2'h3) ? wrSeen_ff
		: wrSeen_ff + 2'h1;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st1Valid_ff <= 1'b0;
			st2Valid_ff <= 1'b0;
			st1Addr_ff  <= '0;
			st2Addr_ff  <= '0;
			st1Data_ff  <= '0;
			st2Data_ff  <= '0;
			wrSeen_ff   <= '0;
		end else if (wrDmemOk) begin
			st1Valid_ff <= 1'b1;
			st2Valid_ff <= st1Valid_ff;
			st1Addr_ff  <= dmemIdx;
			st2Addr_ff  <= st1Addr_ff;
			st1Data_ff  <= regWdata[DMEM_WIDTH-1:0];
			st2Data_ff  <= st1Data_ff;
			wrSeen_ff   <= nxt_wrSeen;
		end
	end

	dsp_data_ram #(
		.DEPTH (DMEM_DEPTH),
		.AW    (DMEM_AW),
		.WIDTH (DMEM_WIDTH)
	) u_ram (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.wrEn      (ramWe),
		.wrAddr    (st2Addr_ff),
		.wrData    (st2Data_ff),
		.rdAddr    (dmemIdx),
		.rdData_ff (ramRd)
	);

	// ------------------------------------------------------------------
	// Read path, answer two cycles after the request
	// ------------------------------------------------------------------
	rd_sel_e    sel_ff, nxt_sel;
	logic [1:0] rdPh_ff, nxt_rdPh;
	logic       pend_ff, nxt_pend;
	logic [31:0] nxt_rdata;

	always_comb begin
		nxt_pend = regRead;
		nxt_rdPh = phIdx;
		nxt_sel  = SEL_NONE;
		if (inDmem)
			nxt_sel = SEL_DMEM;
		else if (regAddr == RUN_ADDR)
			nxt_sel = SEL_RUN;
		else if (regAddr == STATUS_ZERO_ADDR)
			nxt_sel = SEL_STATUS;
		else if (regAddr == IRQ_MASK_ZERO_ADDR)
			nxt_sel = SEL_MASK;
		else if (regAddr == CFG_TWO_ADDR)
			nxt_sel = SEL_CFG2;
		else if (isPhcal)
			nxt_sel = SEL_PHCAL;
		nxt_rdata = '0;
		case (sel_ff)
			SEL_DMEM:   nxt_rdata = 32'(ramRd);
			SEL_RUN:    nxt_rdata = 32'(run_ff);
			SEL_STATUS: nxt_rdata[DONE_BIT] = done_ff;
			SEL_MASK:   nxt_rdata[DONE_BIT] = mask_ff;
			SEL_CFG2:   nxt_rdata[EXTREF_BIT] = extRef_ff;
			SEL_PHCAL:  nxt_rdata = 32'(phCal_ff[rdPh_ff]);
			default:    nxt_rdata = '0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sel_ff    <= SEL_NONE;
			rdPh_ff   <= '0;
			pend_ff   <= 1'b0;
			regRdata  <= '0;
			regRvalid <= 1'b0;
		end else begin
			sel_ff    <= nxt_sel;
			rdPh_ff   <= nxt_rdPh;
			pend_ff   <= nxt_pend;
			regRdata  <= pend_ff ? nxt_rdata : regRdata;
			regRvalid <= pend_ff;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_done_on_pass: assert property (
		tick && run_ff == RUN_START |=> done_ff && passStrobe)
		else $error("done flag not set at end of pass");
	a_irq_follows: assert property (
		done_ff && mask_ff |=> !interruptZeroN)
		else $error("interrupt pin not low for masked done");
	a_done_clear: assert property (
		regWrite && regAddr == STATUS_ZERO_ADDR && regWdata[DONE_BIT] &&
		!(tick && run_ff == RUN_START) |=> !done_ff ##1 interruptZeroN)
		else $error("done flag not cleared by write of one");
	a_protect_block: assert property (
		regWrite && inDmem && protect_ff |=>
		$stable(st1Data_ff) && $stable(st1Valid_ff) && !ramWe)
		else $error("protected memory write entered pipeline");
	a_key_enable: assert property (
		(wrKey && regWdata[7:0] == PROT_KEY ##1
		 wrProt && regWdata[7:0] == PROT_ON) or
		(wrKey && regWdata[7:0] == PROT_KEY ##1 !regWrite ##1
		 wrProt && regWdata[7:0] == PROT_ON) |=> protect_ff)
		else $error("key sequence did not enable protection");
	a_key_disable: assert property (
		(wrKey && regWdata[7:0] == PROT_KEY ##1
		 wrProt && regWdata[7:0] == PROT_OFF) or
		(wrKey && regWdata[7:0] == PROT_KEY ##1 !regWrite ##1
		 wrProt && regWdata[7:0] == PROT_OFF) |=> !protect_ff)
		else $error("key sequence did not disable protection");
	a_key_needed: assert property (
		wrProt && !keyArmed_ff |=> protect_ff == $past(protect_ff))
		else $error("protection changed without key");
	a_run_start: assert property (
		regWrite && regAddr == RUN_ADDR && regWdata[15:0] == RUN_START
		|=> ##1 dspRunning)
		else $error("processor did not start");
	a_phcal_legal: assert property (
		phaseShift[0] <= PHCAL_MAX_DLY ||
		(PHCAL_W'(0) - phaseShift[0]) <= PHCAL_MAX_ADV)
		else $error("phase shift outside legal range");
	a_read_answer: assert property (
		regRead && isPhcal |-> ##2 regRvalid &&
		regRdata[31:PHCAL_W] == '0)
		else $error("calibration read late or upper bits set");
	a_commit_late: assert property (
		wrDmemOk |-> ramWe == (wrSeen_ff >= 2'h2))
		else $error("memory write commit disagrees with write count");
endmodule // dsp_run_ram_protect
`default_nettype wire

/* File: tb/host_model.sv */
// Host model that drives the register port and the power mode
`timescale 1ns/1ns
`default_nettype none
module host_model
	import dsp_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// Register port
	output var  logic        regWrite,
	output var  logic        regRead,
	output var  logic [15:0] regAddr,
	output var  logic [31:0] regWdata,
	// Power mode
	output var  logic [1:0]  powerMode
);
	logic [31:0] expQ[$];

	initial begin
		regWrite  = 1'b0;
		regRead   = 1'b0;
		regAddr   = 16'h0000;
		regWdata  = 32'h00000000;
		powerMode = 2'h0;
	end

	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	// Idle lines show the inverse of the last value, never a stale copy
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		regAddr  <= ~a;
		regWdata <= ~d;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		regRead <= 1'b1;
		regAddr <= a;
		expQ.push_back(e);
		@(posedge sys_clk);
		regRead <= 1'b0;
		regAddr <= ~a;
	endtask

	task automatic mode(input logic [1:0] m);
		@(posedge sys_clk);
		powerMode <= m;
	endtask

	// ------------------------------------------------------------------
	// Host procedures
	// ------------------------------------------------------------------
	function automatic logic [31:0] enc(input int c);
		return (c <= 0) ? 32'(-c) : 32'(c + 512);
	endfunction

	task automatic protect(input logic on);
		wr(PROT_KEY_ADDR, 32'(PROT_KEY));
		wr(PROT_CTRL_ADDR, on ? 32'(PROT_ON) : 32'(PROT_OFF));
	endtask

	// Final write repeated so the two-stage pipeline is flushed
	task automatic memWr(input logic [15:0] a, input logic [31:0] d);
		repeat (3) wr(a, d);
	endtask
endmodule // host_model
`default_nettype wire

/* File: tb/test_dsp_run_and_ram_protect.sv */
// Self-checking bench for the run control and memory protection block
`timescale 1ns/1ns
`default_nettype none
module test_dsp_run_and_ram_protect;
	import dsp_ctrl_pkg::*;
	localparam int PASS = 16;

	logic              sys_clk = 1'b0;
	logic              resetn = 1'b0;
	logic              regWrite, regRead, regRvalid;
	logic [15:0]       regAddr;
	logic [31:0]       regWdata, regRdata;
	logic [1:0]        powerMode;
	logic              dspRunning, passStrobe, externalRefSelect;
	logic [2:0][9:0]   phaseShift;
	logic              interruptZeroN;
	int                errors = 0;
	int                checked = 0;
	int                cyc = 0;
	int                seed, t0, k, c, j, n;
	logic [31:0]       d, e, g;
	logic [9:0]        sh[3];
	logic [31:0]       cd[3];
	int                cor[7] = '{-383, -1, 0, 1, 63, 64, -384};

	always #10 sys_clk = ~sys_clk;

	dsp_run_ram_protect #(.PASS_CYCLES_P(PASS)) u_dsp_run_ram_protect (
		.sys_clk(sys_clk), .resetn(resetn), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .regRvalid(regRvalid),
		.powerMode(powerMode), .dspRunning(dspRunning),
		.passStrobe(passStrobe), .externalRefSelect(externalRefSelect),
		.phaseShift(phaseShift), .interruptZeroN(interruptZeroN));

	host_model u_host_model (
		.sys_clk(sys_clk), .resetn(resetn), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.powerMode(powerMode));

	// ------------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s: expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Oldest noted read result is matched to each answer
	always @(negedge sys_clk) begin
		if (regRvalid === 1'b1) begin
			if (u_host_model.expQ.size() == 0)
				check("spare answer", 32'h1, 32'h0);
			else
				check("read data", regRdata,
				      u_host_model.expQ.pop_front());
		end
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			end_sim();
		end
	end

	task automatic waitStrobe();
		int i;
		for (i = 0; i < 40; i++) begin
			@(negedge sys_clk);
			if (passStrobe === 1'b1)
				break;
		end
		check("strobe seen", 32'(i < 40), 32'h1);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		seed = 54569;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		check("running", dspRunning, 32'h0);
		check("irq pin", interruptZeroN, 32'h1);
		check("ref select", externalRefSelect, 32'h0);
		check("shift", phaseShift, 32'h0);
		u_host_model.rd(RUN_ADDR, 32'(RUN_RESET));
		u_host_model.rd(DMEM_LAST, 32'h0);
		u_host_model.rd(16'h43bf, 32'h0);
		$display("test reset done");

		d = $random(seed) & 32'h0fffffff;
		e = ~d & 32'h0fffffff;
		u_host_model.wr(DMEM_FIRST, d);
		u_host_model.rd(DMEM_FIRST, 32'h0);
		u_host_model.wr(DMEM_LAST, e);
		u_host_model.rd(DMEM_FIRST, 32'h0);
		u_host_model.wr(DMEM_LAST, e);
		u_host_model.rd(DMEM_FIRST, d);
		u_host_model.wr(DMEM_LAST, e);
		u_host_model.rd(DMEM_LAST, e);
		$display("test pipeline done");

		u_host_model.protect(1'b1);
		u_host_model.memWr(DMEM_FIRST, 32'h0abcdef);
		u_host_model.rd(DMEM_FIRST, d);
		u_host_model.wr(PROT_KEY_ADDR, 32'(PROT_KEY));
		u_host_model.wr(IRQ_MASK_ZERO_ADDR, 32'h0);
		u_host_model.wr(PROT_CTRL_ADDR, 32'(PROT_OFF));
		u_host_model.wr(PROT_KEY_ADDR, 32'(PROT_KEY));
		u_host_model.wr(PROT_CTRL_ADDR, 32'h55);
		u_host_model.memWr(DMEM_FIRST, 32'h0abcdef);
		u_host_model.rd(DMEM_FIRST, d);
		u_host_model.protect(1'b0);
		u_host_model.memWr(DMEM_FIRST, e);
		u_host_model.rd(DMEM_FIRST, e);
		$display("test protection done");

		u_host_model.wr(IRQ_MASK_ZERO_ADDR, 32'h1 << DONE_BIT);
		u_host_model.wr(RUN_ADDR, 32'(RUN_START));
		repeat (2) @(negedge sys_clk);
		check("running", dspRunning, 32'h1);
		waitStrobe();
		t0 = cyc;
		waitStrobe();
		check("pass period", 32'(cyc - t0), 32'(PASS));
		check("irq pin", interruptZeroN, 32'h0);
		u_host_model.rd(STATUS_ZERO_ADDR, 32'h1 << DONE_BIT);
		// Clear just after a pass so no new pass lands in the window
		waitStrobe();
		u_host_model.wr(STATUS_ZERO_ADDR, 32'h0);
		repeat (2) @(negedge sys_clk);
		check("irq pin", interruptZeroN, 32'h0);
		u_host_model.wr(STATUS_ZERO_ADDR, 32'h1 << DONE_BIT);
		repeat (2) @(negedge sys_clk);
		check("irq pin", interruptZeroN, 32'h1);
		g = $random(seed) & 32'h0fffffff;
		u_host_model.memWr(DMEM_LAST, g);
		u_host_model.rd(DMEM_LAST, g);
		u_host_model.wr(RUN_ADDR, 32'(RUN_STOP));
		repeat (2) @(negedge sys_clk);
		check("running", dspRunning, 32'h0);
		n = 0;
		repeat (3 * PASS) begin
			@(negedge sys_clk);
			n += (passStrobe === 1'b1);
		end
		check("stopped passes", 32'(n), 32'h0);
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		u_host_model.rd(DMEM_LAST, 32'h0);
		$display("test run done");

		for (j = 0; j < 3; j++) begin
			sh[j] = 10'h000;
			cd[j] = 32'h0;
		end
		for (k = 0; k < 8; k++) begin
			j = k % 3;
			c = (k < 7) ? cor[k] : 0;
			d = (k < 7) ? u_host_model.enc(c) : 32'h200;
			u_host_model.wr(PHCAL_A_ADDR + 16'(j), d);
			if (k < 5) begin
				sh[j] = 10'(c);
				cd[j] = d;
			end
			repeat (2) @(negedge sys_clk);
			check("shift", phaseShift[j], sh[j]);
			u_host_model.rd(PHCAL_A_ADDR + 16'(j), cd[j]);
		end
		$display("test phase done");

		u_host_model.wr(CFG_TWO_ADDR, 32'h1);
		repeat (2) @(negedge sys_clk);
		check("ref select", externalRefSelect, 32'h1);
		for (j = 1; j < 4; j++) begin
			u_host_model.mode(2'(j));
			u_host_model.wr(CFG_TWO_ADDR, 32'h0);
			repeat (2) @(negedge sys_clk);
			check("ref kept", externalRefSelect, 32'h1);
		end
		u_host_model.mode(2'h0);
		u_host_model.rd(CFG_TWO_ADDR, 32'h1);
		u_host_model.wr(CFG_TWO_ADDR, 32'h0);
		repeat (2) @(negedge sys_clk);
		check("ref select", externalRefSelect, 32'h0);
		$display("test config done");
		repeat (5) @(negedge sys_clk);
		check("reads left", 32'(u_host_model.expQ.size()), 32'h0);
		end_sim();
	end
endmodule // test_dsp_run_and_ram_protect
`default_nettype wire
